//--- hw/epd_pkg.sv
/*
 * Shared constants and types for the expansion port decoder:
 * port window, connector bases, strobe timing, FSM states, carriers.
 * Assumes a single 200 MHz clock domain.
 */
package epd_pkg;

	// ==========================================================
	// Port window and connector bases
	localparam logic [15:0] EPD_WIN_LO     = 16'h0080;  // First claimed port
	localparam logic [15:0] EPD_WIN_HI     = 16'h00BF;  // Last claimed port
	localparam logic [15:0] EPD_SLOT0_BASE = 16'h0080;  // First expansion socket
	localparam logic [15:0] EPD_SLOT1_BASE = 16'h00A0;  // Second expansion socket
	localparam int          EPD_NUM_SLOTS  = 2;

	// ==========================================================
	// Strobe timing
	localparam int EPD_CLK_PERIOD_NS = 5;   // 200 MHz
	localparam int EPD_STROBE_MIN_NS = 20;  // Least command strobe width
	localparam int EPD_STROBE_MIN_CYC_RAW =
		(EPD_STROBE_MIN_NS + EPD_CLK_PERIOD_NS - 1) / EPD_CLK_PERIOD_NS;
	localparam int EPD_STROBE_MIN_CYC =
		(EPD_STROBE_MIN_CYC_RAW < 1) ? 1 : EPD_STROBE_MIN_CYC_RAW;
	localparam int          EPD_CNT_W       = 3;
	localparam logic [2:0]  EPD_STROBE_LOAD = 3'(EPD_STROBE_MIN_CYC - 1);
	localparam logic [2:0]  EPD_CNT_ZERO    = 3'h0;

	// ==========================================================
	// Reset values
	localparam logic [1:0] EPD_SEL_RST_N  = 2'h3;  // All selects idle high
	localparam logic [2:0] EPD_ADDR_RST   = 3'h0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		EPD_IDLE   = 2'b00,
		EPD_STROBE = 2'b01
	} epd_state_e;

	typedef struct packed {
		logic [15:0] addr;  // Processor I/O port address
		logic        wr;    // 1 write, 0 read
		logic        dma;   // Cycle belongs to a DMA transfer
	} epd_io_cmd_s;

	typedef struct packed {
		logic low;   // Low chip select wanted
		logic high;  // High chip select wanted
	} epd_sel_s;

endpackage

//--- hw/epd_slot_decode.sv
/*
 * Per-connector chip select decode.
 * Pure combinational; the caller registers the result.
 */
`timescale 1ns/10ps

module epd_slot_decode
	import epd_pkg::*;
#(
	parameter logic [15:0] BASE = EPD_SLOT0_BASE  // 32-port block of this socket
) (
	input  wire logic [15:0] addr_i,     // I/O port address
	input  wire logic        present_i,  // Module fitted
	input  wire logic        width16_i,  // Module is 16-bit
	output epd_sel_s         sel_o       // Wanted selects
);

	logic in_slot;

	// ==========================================================
	// Block match on the upper address bits
	assign in_slot = present_i && (addr_i[15:5] == BASE[15:5]);

	// Width picks the decode; upper half unused by 16-bit modules
	always_comb begin
		sel_o = '0;
		if (in_slot) begin
			if (width16_i) begin
				if (!addr_i[4]) begin
					sel_o.low  = !addr_i[0];  // Even port
					sel_o.high = addr_i[0];   // Odd port
				end
			end else begin
				sel_o.low  = !addr_i[4];  // Lower 16 ports
				sel_o.high = addr_i[4];   // Upper 16 ports
			end
		end
	end

endmodule

//--- hw/epd_expansion_port_decode.sv
/*
 * Expansion port decoder for two plug-in I/O module connectors.
 * Assumes io_req_i/io_cmd_i come from processor logic on mclk_i, and
 * module pins (present, wait, option lines) are asynchronous.
 */
// What this block does
// - Two connectors, each 8- or 16-bit decode
// - No DMA cycles reach a module
// - Wait line stretches module cycle until ready
// - Claim non-DMA 0080H-00BFH cycles when any module fitted
// - No module: window goes to system bus
// - 8-bit first socket: 80-8F low, 90-9F high
// - 8-bit: address bit zero ignored
// - 16-bit: even ports low, odd high, 16 ports
// - Two option lines per connector, strappable
`timescale 1ns/10ps

module epd_expansion_port_decode
	import epd_pkg::*;
(
	input  wire logic        mclk_i,                   // 200 MHz clock
	input  wire logic        arst_n_i,                 // Async reset, low
	input  wire logic        io_req_i,                 // I/O cycle start pulse
	input  epd_io_cmd_s      io_cmd_i,                 // Address, direction, DMA
	input  wire logic [1:0]  width16_i,                // Per socket 16-bit module
	input  wire logic [1:0]  module_present_n_i,       // Pin, module fitted
	input  wire logic [1:0]  module_wait_n_i,          // Pin, module not ready
	input  wire logic [1:0]  option_line_zero_i,       // Pin level
	input  wire logic [1:0]  option_line_one_i,        // Pin level
	input  wire logic [1:0]  opt_zero_drive_i,         // Host drives line zero
	input  wire logic [1:0]  opt_one_drive_i,          // Host drives line one
	input  wire logic [1:0]  opt_zero_from_host_i,     // Level to drive
	input  wire logic [1:0]  opt_one_from_host_i,      // Level to drive
	output logic [1:0]       option_line_zero_o,       // Pin drive value
	output logic [1:0]       option_line_zero_oe_o,    // Pin drive enable
	output logic [1:0]       option_line_one_o,        // Pin drive value
	output logic [1:0]       option_line_one_oe_o,     // Pin drive enable
	output logic [1:0]       opt_zero_to_host_o,       // Synced pin level
	output logic [1:0]       opt_one_to_host_o,        // Synced pin level
	output logic [1:0]       module_select_low_n_o,    // Low chip select
	output logic [1:0]       module_select_high_n_o,   // High chip select
	output logic [2:0]       module_addr_o,            // Module register address
	output logic             io_read_n_o,              // Read strobe
	output logic             io_write_n_o,             // Write strobe
	output logic             claim_onboard_o,          // Cycle taken on board
	output logic             offboard_req_o,           // Pass cycle to system bus
	output logic             io_done_o                 // On-board cycle finished
);

	// ==========================================================
	// Pin synchronisers
	logic [1:0] pres_s1_q, pres_s2_q, wait_s1_q, wait_s2_q;
	logic [1:0] optz_s1_q, optz_s2_q, opto_s1_q, opto_s2_q;

	// Two flops on every asynchronous pin; only stage two is read
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pres_s1_q <= 2'h3;
			pres_s2_q <= 2'h3;
			wait_s1_q <= 2'h3;
			wait_s2_q <= 2'h3;
			optz_s1_q <= 2'h0;
			optz_s2_q <= 2'h0;
			opto_s1_q <= 2'h0;
			opto_s2_q <= 2'h0;
		end else begin
			pres_s1_q <= module_present_n_i;
			pres_s2_q <= pres_s1_q;
			wait_s1_q <= module_wait_n_i;
			wait_s2_q <= wait_s1_q;
			optz_s1_q <= option_line_zero_i;
			optz_s2_q <= optz_s1_q;
			opto_s1_q <= option_line_one_i;
			opto_s2_q <= opto_s1_q;
		end
	end

	// ==========================================================
	// Option lines: strap either way per line, registered both ways
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			option_line_zero_o    <= 2'h0;
			option_line_zero_oe_o <= 2'h0;
			option_line_one_o     <= 2'h0;
			option_line_one_oe_o  <= 2'h0;
			opt_zero_to_host_o    <= 2'h0;
			opt_one_to_host_o     <= 2'h0;
		end else begin
			option_line_zero_o    <= opt_zero_from_host_i;
			option_line_zero_oe_o <= opt_zero_drive_i;
			option_line_one_o     <= opt_one_from_host_i;
			option_line_one_oe_o  <= opt_one_drive_i;
			opt_zero_to_host_o    <= optz_s2_q;
			opt_one_to_host_o     <= opto_s2_q;
		end
	end

	// ==========================================================
	// Decode per connector
	logic [1:0] present;
	logic [1:0] want_lo, want_hi;
	epd_sel_s   slot_sel [EPD_NUM_SLOTS];

	assign present = ~pres_s2_q;

	// Same decoder, different base, per socket
	for (genvar s = 0; s < EPD_NUM_SLOTS; s++) begin : g_slot
		epd_slot_decode #(
			.BASE ((s == 0) ? EPD_SLOT0_BASE : EPD_SLOT1_BASE)
		) u_dec (
			.addr_i    (io_cmd_i.addr),
			.present_i (present[s]),
			.width16_i (width16_i[s]),
			.sel_o     (slot_sel[s])
		);
		assign want_lo[s] = slot_sel[s].low;
		assign want_hi[s] = slot_sel[s].high;
	end

	// Non-DMA window cycle claimed whenever any module sits, even if no select hits
	logic in_window, claim_now;
	assign in_window = (io_cmd_i.addr >= EPD_WIN_LO) && (io_cmd_i.addr <= EPD_WIN_HI);
	assign claim_now = (|present) && in_window && !io_cmd_i.dma;

	// ==========================================================
	// Cycle state machine
	epd_state_e     state_q, state_d;
	logic [2:0]     cnt_q, cnt_d;
	logic [1:0]     sel_lo_n_d, sel_hi_n_d;
	logic [2:0]     addr_d;
	logic           rd_n_d, wr_n_d, claim_d, offb_d, done_d;
	logic [1:0]     active_slot;
	logic           wait_ok;

	// Only the socket being accessed may hold the cycle
	assign active_slot = ~(module_select_low_n_o & module_select_high_n_o);
	assign wait_ok     = &(wait_s2_q | ~active_slot);

	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		sel_lo_n_d = module_select_low_n_o;
		sel_hi_n_d = module_select_high_n_o;
		addr_d     = module_addr_o;
		rd_n_d     = io_read_n_o;
		wr_n_d     = io_write_n_o;
		claim_d    = claim_onboard_o;
		offb_d     = 1'b0;
		done_d     = 1'b0;
		case (state_q)
			EPD_IDLE: begin
				claim_d = 1'b0;
				if (io_req_i) begin
					addr_d = io_cmd_i.addr[3:1];  // Bit zero dropped
					if (claim_now) begin
						claim_d = 1'b1;
						if (|{want_lo, want_hi}) begin
							sel_lo_n_d = ~want_lo;
							sel_hi_n_d = ~want_hi;
							rd_n_d     = io_cmd_i.wr;
							wr_n_d     = !io_cmd_i.wr;
							cnt_d      = EPD_STROBE_LOAD;
							state_d    = EPD_STROBE;
						end else begin
							done_d = 1'b1;  // Hole in window, no select
						end
					end else begin
						offb_d = 1'b1;  // DMA or unclaimed goes off board
					end
				end
			end
			EPD_STROBE: begin
				if (cnt_q != EPD_CNT_ZERO) begin
					cnt_d = cnt_q - 3'h1;
				end else if (wait_ok) begin  // Hold while module waits
					sel_lo_n_d = EPD_SEL_RST_N;
					sel_hi_n_d = EPD_SEL_RST_N;
					rd_n_d     = 1'b1;
					wr_n_d     = 1'b1;
					claim_d    = 1'b0;
					done_d     = 1'b1;
					state_d    = EPD_IDLE;
				end
			end
			default: begin
				state_d = EPD_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q                <= EPD_IDLE;
			cnt_q                  <= EPD_CNT_ZERO;
			module_select_low_n_o  <= EPD_SEL_RST_N;
			module_select_high_n_o <= EPD_SEL_RST_N;
			module_addr_o          <= EPD_ADDR_RST;
			io_read_n_o            <= 1'b1;
			io_write_n_o           <= 1'b1;
			claim_onboard_o        <= 1'b0;
			offboard_req_o         <= 1'b0;
			io_done_o              <= 1'b0;
		end else begin
			state_q                <= state_d;
			cnt_q                  <= cnt_d;
			module_select_low_n_o  <= sel_lo_n_d;
			module_select_high_n_o <= sel_hi_n_d;
			module_addr_o          <= addr_d;
			io_read_n_o            <= rd_n_d;
			io_write_n_o           <= wr_n_d;
			claim_onboard_o        <= claim_d;
			offboard_req_o         <= offb_d;
			io_done_o              <= done_d;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	logic take;
	assign take = (state_q == EPD_IDLE) && io_req_i;

	AST_ONE_SEL:
	assert property ($countones({~module_select_low_n_o, ~module_select_high_n_o}) <= 1)
		else $error("more than one chip select active");
	AST_CLAIM:
	assert property (take && (|present) && in_window && !io_cmd_i.dma |=> claim_onboard_o)
		else $error("window not claimed with module fitted");
	AST_ABSENT:
	assert property (take && !(|present) |=> offboard_req_o && !claim_onboard_o)
		else $error("window claimed with no module");
	AST_NO_DMA:
	assert property (take && io_cmd_i.dma
		|=> offboard_req_o && (&module_select_low_n_o) && (&module_select_high_n_o))
		else $error("dma cycle reached a module");
	AST_S0_8BIT:
	assert property (take && present[0] && !width16_i[0] && !io_cmd_i.dma
		&& io_cmd_i.addr[15:4] == 12'h009 |=> !module_select_high_n_o[0])
		else $error("first socket upper ports miss high select");
	AST_S1_8BIT:
	assert property (take && present[1] && !width16_i[1] && !io_cmd_i.dma
		&& io_cmd_i.addr[15:4] == 12'h00A |=> !module_select_low_n_o[1])
		else $error("second socket lower ports miss low select");
	AST_16BIT:
	assert property (take && present[0] && width16_i[0] && !io_cmd_i.dma
		&& io_cmd_i.addr[15:4] == 12'h008
		|=> module_select_low_n_o[0] == $past(io_cmd_i.addr[0])
		&& module_select_high_n_o[0] == !$past(io_cmd_i.addr[0]))
		else $error("16-bit even/odd select wrong");
	AST_REG_ADDR:
	assert property (take |=> module_addr_o == $past(io_cmd_i.addr[3:1]))
		else $error("module register address wrong");
	AST_MIN_STROBE:
	assert property ($fell(io_read_n_o & io_write_n_o) |-> !(io_read_n_o & io_write_n_o) [*4])
		else $error("command strobe too short");
	AST_WAIT_HOLD:
	assert property (state_q == EPD_STROBE && cnt_q == EPD_CNT_ZERO && !wait_ok
		|=> state_q == EPD_STROBE && !(io_read_n_o & io_write_n_o))
		else $error("cycle ended while module waits");
	AST_OPT_IN:
	assert property (opt_zero_to_host_o == $past(option_line_zero_i, 3))
		else $error("option line zero not passed to host");

	COV_READ8: cover property (take && !io_cmd_i.wr && claim_now && !width16_i[0] ##1 1 ##[4:20] io_done_o);
	COV_WRITE16: cover property (take && io_cmd_i.wr && claim_now && width16_i[1]);
	COV_OFFBOARD: cover property (offboard_req_o);
	COV_STRETCH: cover property (state_q == EPD_STROBE && cnt_q == EPD_CNT_ZERO && !wait_ok [*3]);

endmodule

//--- sim/epd_module_model.sv
/*
 * Plug-in I/O module model for both connectors.
 * Assumes select lines come from the decoder; the bench sets fit and stall.
 */
`timescale 1ns/10ps

module epd_module_model (
	input  wire logic       mclk_i,      // Board clock
	input  wire logic [1:0] fitted_i,    // Sockets holding a module
	input  wire logic [7:0] stall_i,     // Not-ready cycles per access
	input  wire logic [1:0] sel_low_n_i, // Low chip selects
	input  wire logic [1:0] sel_hi_n_i,  // High chip selects
	output logic [1:0]      present_n_o, // Module fitted, low
	output logic [1:0]      wait_n_o     // Module not ready, low
);
	logic [7:0] cnt_q [2];
	logic [1:0] sel;

	// ==========================================================
	// Presence and wait
	assign present_n_o = ~fitted_i;
	assign sel = ~(sel_low_n_i & sel_hi_n_i);

	// Count cycles since select; idle sockets keep the line released high
	always_ff @(posedge mclk_i) begin
		for (int s = 0; s < 2; s++) begin
			if (!sel[s])
				cnt_q[s] <= 8'h00;
			else if (cnt_q[s] != 8'hFF)
				cnt_q[s] <= cnt_q[s] + 8'h01;
		end
	end

	// Hold wait low until the stall has run out
	always_comb begin
		for (int s = 0; s < 2; s++)
			wait_n_o[s] = ~(sel[s] & (cnt_q[s] < stall_i));
	end
endmodule

//--- sim/tb.sv
/*
 * Self-checking bench for the expansion port decoder.
 * Assumes the module model on both sockets; inputs move on falling edges.
 */
`timescale 1ns/10ps

module tb
	import epd_pkg::*;
;
	logic        mclk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        io_req = 1'b0;
	epd_io_cmd_s io_cmd = '0;
	logic [1:0]  w16 = 2'h0, fitted = 2'h0, drv0 = 2'h0, val0 = 2'h0, mod0 = 2'h0, mod1 = 2'h0;
	logic [1:0]  drv1 = 2'h0, val1 = 2'h0;
	logic [7:0]  stall = 8'h00;
	logic [1:0]  pres_n, wait_n, o0, oe0, o1, oe1, th0, th1, lo_n, hi_n;
	logic [2:0]  maddr;
	logic        rd_n, wr_n, claim, offb, done;
	logic [1:0]  s_lo, s_hi, kind;
	logic        s_rd, s_wr, s_claim;
	int          fails = 0, compares = 0, cyc;
	logic [15:0] eight_tab [10] = '{16'h0080, 16'h0081, 16'h008F, 16'h0090, 16'h009F,
		16'h00A0, 16'h00AF, 16'h00B0, 16'h00B1, 16'h00BF};
	logic [15:0] wide_tab [6] = '{16'h0080, 16'h0081, 16'h008E, 16'h008F, 16'h00A2, 16'h00AF};
	// Pin level: host drive wins over the module
	wire logic [1:0] pin0 = (oe0 & o0) | (~oe0 & mod0);
	wire logic [1:0] pin1 = (oe1 & o1) | (~oe1 & mod1);

	always #2.5 mclk_i = ~mclk_i;

	epd_expansion_port_decode uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .io_req_i(io_req),
		.io_cmd_i(io_cmd), .width16_i(w16), .module_present_n_i(pres_n),
		.module_wait_n_i(wait_n), .option_line_zero_i(pin0), .option_line_one_i(pin1),
		.opt_zero_drive_i(drv0), .opt_one_drive_i(drv1), .opt_zero_from_host_i(val0),
		.opt_one_from_host_i(val1), .option_line_zero_o(o0), .option_line_zero_oe_o(oe0),
		.option_line_one_o(o1), .option_line_one_oe_o(oe1), .opt_zero_to_host_o(th0),
		.opt_one_to_host_o(th1), .module_select_low_n_o(lo_n), .module_select_high_n_o(hi_n),
		.module_addr_o(maddr), .io_read_n_o(rd_n), .io_write_n_o(wr_n),
		.claim_onboard_o(claim), .offboard_req_o(offb), .io_done_o(done));

	epd_module_model partner (.mclk_i(mclk_i), .fitted_i(fitted), .stall_i(stall),
		.sel_low_n_i(lo_n), .sel_hi_n_i(hi_n), .present_n_o(pres_n), .wait_n_o(wait_n));

	// ==========================================================
	// Shared tasks
	task results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task setup(input logic [1:0] f, input logic [1:0] w);
		@(negedge mclk_i);
		fitted = f;
		w16 = w;
		repeat (4) @(negedge mclk_i);  // Presence crosses a two-flop sync
	endtask

	// One request; gathers selects and strobes until the answer comes
	task io(input logic [15:0] a, input logic dma);
		@(negedge mclk_i);
		io_req = 1'b1;
		io_cmd = '{addr: a, wr: a[0], dma: dma};
		s_lo = 2'h3;
		s_hi = 2'h3;
		s_rd = 1'b1;
		s_wr = 1'b1;
		s_claim = 1'b0;
		kind = 2'h0;
		cyc = 0;
		while (kind == 2'h0 && cyc < 300) begin
			@(negedge mclk_i);
			io_req = 1'b0;
			cyc++;
			s_lo &= lo_n;
			s_hi &= hi_n;
			s_rd &= rd_n;
			s_wr &= wr_n;
			s_claim |= claim;
			if (offb === 1'b1)
				kind = 2'h1;
			else if (done === 1'b1)
				kind = 2'h2;
		end
		if (kind == 2'h0) begin
			fails++;
			results();
		end
	endtask

	// Request that must end with no select; k 1 off board, 2 claimed
	task refuse(input logic [15:0] a, input logic dma, input logic [1:0] k);
		io(a, dma);
		check(8'({kind, s_lo, s_hi, s_claim, 1'b0}), 8'({k, 4'hF, k[1], 1'b0}));
		check(8'(cyc), 8'h01);
	endtask

	// ==========================================================
	// Scenarios
	task t_eight;
		logic [15:0] a;
		setup(2'h3, 2'h0);
		foreach (eight_tab[i]) begin
			a = eight_tab[i];
			io(a, 1'b0);
			check(8'({kind, s_lo, s_hi}), 8'({2'h2, a[4] ? 2'h3 : ~(2'h1 << a[5]),
				a[4] ? ~(2'h1 << a[5]) : 2'h3}));
			check(8'(maddr), 8'(a[3:1]));
			check(8'({s_rd, s_wr, s_claim}), 8'({a[0], ~a[0], 1'b1}));
			check(8'(cyc), 8'h05);
		end
	endtask

	task t_wide;
		logic [15:0] a;
		setup(2'h3, 2'h3);
		foreach (wide_tab[i]) begin
			a = wide_tab[i];
			io(a, 1'b0);
			check(8'({kind, s_lo, s_hi}), 8'({2'h2, a[0] ? 2'h3 : ~(2'h1 << a[5]),
				a[0] ? ~(2'h1 << a[5]) : 2'h3}));
		end
		refuse(16'h0090, 1'b0, 2'h2);
		refuse(16'h00B5, 1'b0, 2'h2);
	endtask

	task t_wait;
		setup(2'h3, 2'h0);
		stall = 8'd10;
		io(16'h0088, 1'b0);
		check(8'({s_lo, s_hi}), 8'h0B);
		check(8'(cyc > 10 && cyc < 17), 8'h01);
		stall = 8'h00;
	endtask

	task t_refused;
		setup(2'h3, 2'h0);
		refuse(16'h0080, 1'b1, 2'h1);
		refuse(16'h007F, 1'b0, 2'h1);
		refuse(16'h00C0, 1'b0, 2'h1);
		setup(2'h1, 2'h0);
		refuse(16'h00A4, 1'b0, 2'h2);
		setup(2'h0, 2'h0);
		refuse(16'h0085, 1'b0, 2'h1);
		refuse(16'h00B0, 1'b0, 2'h1);
	endtask

	task t_option;
		@(negedge mclk_i);
		drv0 = 2'h1;
		val0 = 2'h1;
		drv1 = 2'h2;  // Host drives the second socket's line one
		val1 = 2'h2;
		mod0 = 2'h2;
		mod1 = 2'h2;
		repeat (5) @(negedge mclk_i);
		check(8'({oe0, o0, oe1, o1}), 8'h5A);
		check(8'({th0, th1}), 8'h0E);
		mod0 = 2'h0;
		mod1 = 2'h1;
		repeat (5) @(negedge mclk_i);
		check(8'({th0, th1}), 8'h07);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge mclk_i);
		@(negedge mclk_i);
		arst_n_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		t_eight();
		t_wide();
		t_wait();
		t_refused();
		t_option();
		results();
	end
endmodule
